// ==== spr_core.sv ====
`timescale 1ns/1ps
// Functional notes
// - eight map bytes, one per sector
// - sectors 1-7: FFh protected, 00h free
// - byte 0: bits 7:6 and 5:4 pages
// - map starts at all zero
// - 3D 2A 7F CF then CS high erases
// - busy shown during erase or program
// - erase sets every byte to FFh
// - erase accepted, protection on or off
// - 3D 2A 7F FC plus eight bytes programs
// - ninth data byte wraps to byte zero
// - program accepted, protection on or off
// - program overwrites the data buffer
// - 32h, three dummies, then map out
// - beyond eight bytes output undefined
// - CS high tristates serial output
// - 3D 2A 7F A9 enables protection
// - 3D 2A 7F 9A disables protection
// - write protect blocks map changes
// - write protect ignores disable command
module spr_core
    import spr_pkg::*;
#(
    parameter int ERASE_CYC = SPR_ERASE_CYC,  // shorten in simulation
    parameter int PROG_CYC  = SPR_PROG_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // serial link pins
    input  wire logic        cs_n,
    input  wire logic        sck,
    input  wire logic        si,
    input  wire logic        wp_n,
    output logic             so,
    output logic             so_oe,
    // block state
    output logic             busy,
    output logic             prot_en,
    output logic [7:0]       sector_prot,
    output logic             boot_pages_low,
    output logic             boot_pages_high,
    output logic             buf_clobber
);
    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] cs_s_q;                       // [0] meta stage only
    logic [2:0] sck_s_q;
    logic [1:0] si_s_q;
    logic [1:0] wp_s_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cs_s_q  <= 3'b111;
            sck_s_q <= 3'b000;
            si_s_q  <= 2'b00;
            wp_s_q  <= 2'b11;
        end else begin
            cs_s_q  <= {cs_s_q[1:0], cs_n};
            sck_s_q <= {sck_s_q[1:0], sck};
            si_s_q  <= {si_s_q[0], si};
            wp_s_q  <= {wp_s_q[0], wp_n};
        end
    end
    // edges only look at stages 1 and 2, never the meta stage
    wire cs_low   = ~cs_s_q[1];
    wire cs_rise  = cs_s_q[1] & ~cs_s_q[2];
    wire sck_rise = sck_s_q[1] & ~sck_s_q[2] & cs_low;
    wire sck_fall = ~sck_s_q[1] & sck_s_q[2] & cs_low;
    wire si_bit   = si_s_q[1];
    wire wp_on    = ~wp_s_q[1];

    // ------------------------------------------------------------------
    // shifter and byte counter
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_CMD   = 5'b00010,
        ST_DATA  = 5'b00100,
        ST_OUT   = 5'b01000,
        ST_WORK  = 5'b10000
    } spr_state_t;

    spr_state_t  st_q, st_d;
    logic [2:0]  bit_q;                        // bit within byte
    logic [7:0]  sh_q;                         // input shift register
    logic [3:0]  nbyte_q;                      // command bytes seen (sat.)
    logic [7:0]  op_q;                         // first opcode byte
    logic [7:0]  last_q;                       // fourth command byte
    logic        pfx_ok_q;                     // prefix bytes 2,3 matched
    logic [2:0]  ptr_q;                        // map byte pointer
    logic [7:0]  data_seen_q;                  // working buffer fill
    logic [63:0] buf_q;                        // working storage
    logic [63:0] map_q;                        // nonvolatile map model
    logic [7:0]  obyte_q;                      // output shift byte
    logic        erase_q;                      // self-timed op is erase
    logic [31:0] tmr_q;                        // self-timed counter
    logic        prot_q;                       // global protection state
    logic        so_q, so_oe_q;

    wire [7:0] byte_in  = {sh_q[6:0], si_bit};
    wire       byte_end = sck_rise & (bit_q == 3'd7);
    // prefix matched and the frame sits on a byte boundary
    wire       pfx_seen = (op_q == SPR_PFX0) & pfx_ok_q & (bit_q == 3'd0);
    wire       is_pfx   = pfx_seen & (nbyte_q == 4'd4);
    // map update is refused while write protect is held
    wire       upd_ok   = ~wp_on;
    // erase or program accepted regardless of prot_q
    wire       go_erase = cs_rise & (st_q == ST_CMD) & is_pfx & upd_ok
                          & (last_q == SPR_OP_ERASE);
    // byte count has run past four here, so the data bytes are tested instead
    wire       go_prog  = cs_rise & (st_q == ST_DATA) & pfx_seen & upd_ok
                          & (last_q == SPR_OP_PROG) & (|data_seen_q);
    wire       do_pen   = cs_rise & (st_q == ST_CMD) & is_pfx
                          & (last_q == SPR_OP_PEN);
    wire       do_pdis  = cs_rise & (st_q == ST_CMD) & is_pfx & ~wp_on
                          & (last_q == SPR_OP_PDIS);
    wire       tmr_done = (st_q == ST_WORK) & (tmr_q == 32'd0);

    // next-state decode
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE: if (cs_low) st_d = ST_CMD;
            ST_CMD: begin
                if (go_erase) st_d = ST_WORK;
                else if (cs_rise) st_d = ST_IDLE;
                else if (byte_end && nbyte_q == 4'd0 && byte_in == SPR_OP_READ)
                    st_d = ST_OUT;
                else if (byte_end && nbyte_q == 4'd3 && byte_in == SPR_OP_PROG)
                    st_d = ST_DATA;
            end
            ST_DATA: if (go_prog) st_d = ST_WORK;
                     else if (cs_rise) st_d = ST_IDLE;
            ST_OUT:  if (cs_rise) st_d = ST_IDLE;
            ST_WORK: if (tmr_done) st_d = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // command capture
    // ------------------------------------------------------------------
    // bit count restarts whenever the frame ends
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q     <= ST_IDLE;
            bit_q    <= 3'd0;
            sh_q     <= 8'h00;
            nbyte_q  <= 4'd0;
            op_q     <= 8'h00;
            last_q   <= 8'h00;
            pfx_ok_q <= 1'b0;
        end else begin
            st_q <= st_d;
            if (!cs_low || st_q == ST_IDLE || st_q == ST_WORK) begin
                bit_q    <= 3'd0;
                nbyte_q  <= 4'd0;
                pfx_ok_q <= 1'b1;
            end else if (sck_rise) begin
                bit_q <= bit_q + 3'd1;
                sh_q  <= byte_in;
                if (bit_q == 3'd7) begin
                    if (nbyte_q != 4'hF) nbyte_q <= nbyte_q + 4'd1;
                    if (nbyte_q == 4'd0) op_q <= byte_in;
                    if (nbyte_q == 4'd1 && byte_in != SPR_PFX1) pfx_ok_q <= 1'b0;
                    if (nbyte_q == 4'd2 && byte_in != SPR_PFX2) pfx_ok_q <= 1'b0;
                    if (nbyte_q == 4'd3) last_q <= byte_in;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // working buffer, map, timer, protection
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ptr_q       <= 3'd0;
            data_seen_q <= 8'h00;
            buf_q       <= 64'h0000_0000_0000_0000;
            map_q       <= SPR_MAP_RESET;
            erase_q     <= 1'b0;
            tmr_q       <= 32'd0;
            prot_q      <= 1'b0;
        end else begin
            if (st_q == ST_CMD) begin
                ptr_q       <= 3'd0;
                data_seen_q <= 8'h00;
            end else if (st_q == ST_DATA && byte_end) begin
                // 3-bit pointer wraps so byte nine lands at zero
                buf_q[ptr_q*8 +: 8] <= byte_in;
                data_seen_q[ptr_q]  <= 1'b1;
                ptr_q               <= ptr_q + 3'd1;
            end
            if (go_erase) begin
                erase_q <= 1'b1;
                tmr_q   <= 32'(ERASE_CYC - 1);
            end else if (go_prog) begin
                erase_q <= 1'b0;
                tmr_q   <= 32'(PROG_CYC - 1);
            end else if (st_q == ST_WORK && tmr_q != 32'd0) begin
                tmr_q <= tmr_q - 32'd1;
            end
            // map commits at the end of the timed cycle
            if (tmr_done) begin
                if (erase_q) map_q <= {SPR_MAP_BYTES{SPR_BYTE_PROT}};
                else         map_q <= map_q & buf_q;
            end
            if (do_pen) prot_q <= 1'b1;
            else if (do_pdis) prot_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // serial output, read path
    // ------------------------------------------------------------------
    // output advances on falling sck so host samples on rising
    logic [3:0] rd_idx_q;                     // next map byte to send
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            obyte_q  <= 8'h00;
            rd_idx_q <= 4'd0;
            so_q     <= 1'b0;
            so_oe_q  <= 1'b0;
        end else if (st_q != ST_OUT || !cs_low) begin
            so_oe_q  <= 1'b0;
            rd_idx_q <= 4'd0;
        end else if (sck_fall && nbyte_q >= 4'(1 + SPR_DUMMY_BYTES)) begin
            so_oe_q <= 1'b1;
            if (bit_q == 3'd0) begin
                // past byte seven the map is re-sent, output is undefined
                obyte_q  <= {map_q[rd_idx_q[2:0]*8 +: 8]} << 1;
                so_q     <= map_q[rd_idx_q[2:0]*8 + 7];
                rd_idx_q <= rd_idx_q + 4'd1;
            end else begin
                so_q    <= obyte_q[7];
                obyte_q <= {obyte_q[6:0], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------------
    // protection decode
    // ------------------------------------------------------------------
    logic [7:0] sprot_q;
    logic       blo_q, bhi_q, busy_q, pen_q, clob_q;
    wire        prot_act = prot_q | wp_on;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sprot_q <= 8'h00;
            blo_q   <= 1'b0;
            bhi_q   <= 1'b0;
            busy_q  <= 1'b0;
            pen_q   <= 1'b0;
            clob_q  <= 1'b0;
        end else begin
            for (int i = 1; i < SPR_MAP_BYTES; i++)
                sprot_q[i] <= prot_act & (map_q[i*8 +: 8] == SPR_BYTE_PROT);
            sprot_q[0] <= prot_act & (map_q[7:4] != 4'h0);
            blo_q  <= prot_act & (&map_q[SPR_BOOT_LO_BIT +: 2]);
            bhi_q  <= prot_act & (&map_q[SPR_BOOT_HI_BIT +: 2]);
            busy_q <= (st_d == ST_WORK);
            pen_q  <= prot_act;
            clob_q <= go_prog;
        end
    end

    assign so              = so_q;
    assign so_oe           = so_oe_q;
    assign busy            = busy_q;
    assign prot_en         = pen_q;
    assign sector_prot     = sprot_q;
    assign boot_pages_low  = blo_q;
    assign boot_pages_high = bhi_q;
    assign buf_clobber     = clob_q;
endmodule // spr_core

// ==== spr_host.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// host side of the serial link
// ------------------------------------------------------------
module spr_host
    import spr_pkg::*;
(
    // clock
    input wire logic clk,
    // device answers
    input wire logic busy,
    input wire logic so,
    input wire logic so_oe,
    // pins driven
    output logic     cs_n,
    output logic     sck,
    output logic     si
);
    logic [7:0] rx;  // last byte sampled from so

    // sck stands low outside frames
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end

    // one byte, msb first; each sck phase four clocks
    task automatic xbyte(input logic [7:0] tx);
        for (int i = 7; i >= 0; i--) begin
            si <= tx[i];
            repeat (4) @(posedge clk);
            sck <= 1'b1;
            repeat (4) @(posedge clk);
            // an undriven output reads inverted so a dropped enable shows up
            rx = {rx[6:0], so_oe ? so : ~so};
            sck <= 1'b0;
        end
    endtask

    task automatic frame_open();
        cs_n <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // released si toggles so a stale level is never trusted
    task automatic frame_close();
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        si <= ~si;
        repeat (8) @(posedge clk);
    endtask

    // first nb bytes of the four-byte map command
    task automatic pre(input logic [7:0] op, input int nb);
        logic [31:0] seq;
        seq = {SPR_PFX0, SPR_PFX1, SPR_PFX2, op};
        frame_open();
        for (int i = 0; i < nb; i++) xbyte(seq[31 - 8*i -: 8]);
    endtask

    task automatic cmd(input logic [7:0] op);
        pre(op, 4);
        frame_close();
    endtask

    // caller supplies every byte, all valid codes
    task automatic prog(input logic [7:0] d [9], input int n);
        pre(SPR_OP_PROG, 4);
        for (int i = 0; i < n; i++) xbyte(d[i]);
        frame_close();
    endtask

    task automatic read_map(output logic [63:0] m);
        frame_open();
        xbyte(SPR_OP_READ);
        repeat (SPR_DUMMY_BYTES) xbyte(8'h00);
        for (int i = 0; i < 8; i++) begin
            xbyte(8'h00);
            m[8*i +: 8] = rx;
        end
        frame_close();
    endtask

    // poll ready before the next command; bounded
    task automatic wait_ready();
        for (int n = 0; n < 100 && busy !== 1'b0; n++) @(posedge clk);
    endtask
endmodule // spr_host

// ==== spr_monitor.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checker for the protection map block
// ------------------------------------------------------------
module spr_monitor
    import spr_pkg::*;
#(
    parameter int ERASE_CYC = 20,  // self-timed erase length
    parameter int PROG_CYC  = 20   // self-timed program length
) (
    // clock and reset
    input wire logic       clk,
    input wire logic       rstn,
    // serial pins
    input wire logic       cs_n,
    input wire logic       sck,
    input wire logic       si,
    input wire logic       wp_n,
    input wire logic       so,
    input wire logic       so_oe,
    // block state
    input wire logic       busy,
    input wire logic       prot_en,
    input wire logic [7:0] sector_prot,
    input wire logic       boot_pages_low,
    input wire logic       boot_pages_high,
    input wire logic       buf_clobber
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    logic [15:0] bcnt_q;  // length of the current busy run

    // count busy cycles; cleared while idle so each run starts at zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) bcnt_q <= 16'h0000;
        else bcnt_q <= busy ? bcnt_q + 16'h0001 : 16'h0000;
    end

    property p_busy_len; $fell(busy) |-> bcnt_q == ERASE_CYC || bcnt_q == PROG_CYC; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy run length wrong");
    property p_busy_cs; $rose(busy) |-> cs_n && $past(cs_n, 2); endproperty
    a_busy_cs: assert property (p_busy_cs) else $error("busy without deselect");
    property p_busy_wp; $rose(busy) |-> wp_n && $past(wp_n, 3); endproperty
    a_busy_wp: assert property (p_busy_wp) else $error("map cycle under write protect");
    property p_oe_end; $rose(cs_n) |-> ##[1:6] !so_oe; endproperty
    a_oe_end: assert property (p_oe_end) else $error("output not released");
    property p_oe_sel; $rose(so_oe) |-> !cs_n && !busy; endproperty
    a_oe_sel: assert property (p_oe_sel) else $error("output driven unselected");
    property p_wp_prot; $fell(wp_n) |-> ##[1:6] prot_en; endproperty
    a_wp_prot: assert property (p_wp_prot) else $error("write protect not forcing");
    property p_off_clear;
        !prot_en && !$past(prot_en) && !$past(prot_en, 2) |->
            sector_prot == 8'h00 && !boot_pages_low && !boot_pages_high;
    endproperty
    a_off_clear: assert property (p_off_clear) else $error("protection shown while off");
    property p_boot_sec0; boot_pages_low || boot_pages_high |-> sector_prot[0]; endproperty
    a_boot_sec0: assert property (p_boot_sec0) else $error("sector zero bit mismatch");
    property p_clob_busy; $rose(buf_clobber) |-> ##[0:3] busy; endproperty
    a_clob_busy: assert property (p_clob_busy) else $error("clobber without cycle");
    property p_clob_pulse; buf_clobber |=> !buf_clobber; endproperty
    a_clob_pulse: assert property (p_clob_pulse) else $error("clobber not a pulse");

    c_busy: cover property ($rose(busy));
    c_read: cover property ($rose(so_oe));
    c_prog: cover property (buf_clobber);
endmodule // spr_monitor

bind spr_core spr_monitor #(.ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC)) spr_monitor_i (
    .clk(clk), .rstn(rstn), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
    .so(so), .so_oe(so_oe), .busy(busy), .prot_en(prot_en), .sector_prot(sector_prot),
    .boot_pages_low(boot_pages_low), .boot_pages_high(boot_pages_high),
    .buf_clobber(buf_clobber));

// ==== spr_pkg.sv ====
package spr_pkg;
    // ------------------------------------------------------------------
    // command bytes
    // ------------------------------------------------------------------
    localparam logic [7:0] SPR_PFX0      = 8'h3D;   // three-byte prefix, byte 1
    localparam logic [7:0] SPR_PFX1      = 8'h2A;   // prefix byte 2
    localparam logic [7:0] SPR_PFX2      = 8'h7F;   // prefix byte 3
    localparam logic [7:0] SPR_OP_ERASE  = 8'hCF;   // map erase
    localparam logic [7:0] SPR_OP_PROG   = 8'hFC;   // map program
    localparam logic [7:0] SPR_OP_PEN    = 8'hA9;   // protection enable
    localparam logic [7:0] SPR_OP_PDIS   = 8'h9A;   // protection disable
    localparam logic [7:0] SPR_OP_READ   = 8'h32;   // map read
    localparam logic [7:0] SPR_OP_STAT   = 8'hD7;   // status read
    // ------------------------------------------------------------------
    // map layout and values
    // ------------------------------------------------------------------
    localparam int         SPR_MAP_BYTES = 8;       // sectors 0..7
    localparam logic [7:0] SPR_BYTE_PROT = 8'hFF;   // protected / erased
    localparam logic [7:0] SPR_BYTE_FREE = 8'h00;   // unprotected
    localparam logic [63:0] SPR_MAP_RESET = 64'h0000_0000_0000_0000; // shipped value
    localparam int         SPR_BOOT_LO_BIT = 6;     // byte 0 bits 7:6
    localparam int         SPR_BOOT_HI_BIT = 4;     // byte 0 bits 5:4
    localparam int         SPR_STAT_RDY_BIT = 7;    // ready/busy in status
    localparam int         SPR_STAT_PROT_BIT = 1;   // protection enabled
    localparam int         SPR_DUMMY_BYTES = 3;     // after read opcode
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int         SPR_CLK_MHZ   = 40;
    localparam int         SPR_ERASE_US  = 50;      // map_erase_time, max
    localparam int         SPR_PROG_US   = 50;      // map program time, max
    localparam int         SPR_ERASE_CYC = SPR_ERASE_US * SPR_CLK_MHZ;
    localparam int         SPR_PROG_CYC  = SPR_PROG_US * SPR_CLK_MHZ;
endpackage

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
    import spr_pkg::*;
    localparam int CYC = 20;  // shortened self-timed cycles
    logic            clk, rstn, wp_n;
    wire logic       cs_n, sck, si, so, so_oe, busy, prot_en, boot_lo, boot_hi, clob;
    wire logic [7:0] sp;
    int              miscompares = 0, compares = 0, nclob = 0, n0;
    logic [63:0]     m, exp;
    logic [31:0]     r;
    logic [7:0]      d [9];

    spr_core #(.ERASE_CYC(CYC), .PROG_CYC(CYC)) spr_core_i (
        .clk(clk), .rstn(rstn), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
        .so(so), .so_oe(so_oe), .busy(busy), .prot_en(prot_en), .sector_prot(sp),
        .boot_pages_low(boot_lo), .boot_pages_high(boot_hi), .buf_clobber(clob));
    spr_host spr_host_i (.clk(clk), .busy(busy), .so(so), .so_oe(so_oe),
        .cs_n(cs_n), .sck(sck), .si(si));

    always #12.5 clk = ~clk;
    always @(posedge clk) if (clob === 1'b1) nclob++;

    task automatic check(input logic [63:0] got, input logic [63:0] want);
        compares++;
        if (got !== want) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h want=%h", $time, got, want);
        end
    endtask

    // expected {prot_en, sector_prot, boot low, boot high}
    function automatic logic [10:0] st_exp(input logic [63:0] mp, input logic on);
        st_exp[10] = on;
        st_exp[2] = on & (|mp[7:4]);
        for (int i = 1; i < 8; i++) st_exp[i + 2] = on & (mp[8*i +: 8] == SPR_BYTE_PROT);
        st_exp[1] = on & (&mp[7:6]);
        st_exp[0] = on & (&mp[5:4]);
    endfunction

    task automatic chk_st(input logic [63:0] mp, input logic on);
        check(64'({prot_en, sp, boot_lo, boot_hi}), 64'(st_exp(mp, on)));
    endtask

    task automatic results();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        results();
    end

    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        wp_n = 1'b1;
        void'($urandom(3));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        // truncated erase, then the shipped map
        spr_host_i.pre(SPR_OP_ERASE, 3);
        spr_host_i.frame_close();
        check(64'(busy), 64'h0);
        spr_host_i.read_map(m);
        check(m, SPR_MAP_RESET);
        check(64'(so_oe), 64'h0);
        chk_st(m, 1'b0);
        spr_host_i.cmd(SPR_OP_PEN);
        chk_st(m, 1'b1);
        // write protect refuses erase and disable
        wp_n <= 1'b0;
        repeat (6) @(posedge clk);
        spr_host_i.cmd(SPR_OP_ERASE);
        check(64'(busy), 64'h0);
        spr_host_i.cmd(SPR_OP_PDIS);
        wp_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk_st(m, 1'b1);
        spr_host_i.cmd(SPR_OP_ERASE);
        check(64'(busy), 64'h1);
        spr_host_i.wait_ready();
        check(64'(busy), 64'h0);
        spr_host_i.read_map(m);
        check(m, {8{SPR_BYTE_PROT}});
        chk_st(m, 1'b1);
        // first pass all zero, then random valid maps; last pass wraps a ninth byte
        for (int k = 0; k < 4; k++) begin
            r = (k == 0) ? 32'h0 : $urandom;
            d[0] = {{2{r[0]}}, {2{r[1]}}, r[5:2]};
            for (int i = 1; i < 9; i++) d[i] = {8{r[i + 5]}};
            if (k == 3) begin
                d[0] = 8'h00;
                d[8] = 8'hF5;
            end
            for (int i = 0; i < 8; i++) exp[8*i +: 8] = d[i];
            if (k == 3) exp[7:0] = d[8];
            n0 = nclob;
            spr_host_i.cmd(SPR_OP_ERASE);
            spr_host_i.wait_ready();
            spr_host_i.prog(d, (k == 3) ? 9 : 8);
            check(64'(busy), 64'h1);
            check(64'(nclob - n0), 64'h1);
            spr_host_i.wait_ready();
            spr_host_i.read_map(m);
            check(m, exp);
            chk_st(m, 1'b1);
        end
        spr_host_i.cmd(SPR_OP_PDIS);
        chk_st(m, 1'b0);
        results();
    end
endmodule // tb
